// file: common/pcg_params.svh
// offsets, field positions, reset values and counts for the clock control
`ifndef PCG_PARAMS_SVH
`define PCG_PARAMS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PCG_SYNTH_BASE  8'h00
`define PCG_SYSCTL      8'h14
`define PCG_UPDATE      8'h18
`define PCG_STATUS      8'h1c
`define PCG_GATE        8'h20
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PCG_MULT_LSB    0
`define PCG_REFDIV_LSB  8
`define PCG_EXP_LSB     13
`define PCG_DIV_LSB     0
`define PCG_SEL_LSB     8
`define PCG_SRC_BIT     12
`define PCG_UPD_CORE    0
`define PCG_UPD_ARRAY   1
`define PCG_UPD_DIV     2
`define PCG_UPD_SRC     3
`define PCG_ST_BOOT     2
`define PCG_ST_BUSY     3
// ---------------------------------------------------------------
// counts in input reference periods
// ---------------------------------------------------------------
`define PCG_LOCK_FULL   10'd520
`define PCG_LOCK_SHORT  10'd10
`define PCG_BOOT_WAIT   10'd500
// ---------------------------------------------------------------
// strap presets {exp, reference_divider, feedback_multiplier}
// ---------------------------------------------------------------
`define PCG_PRE_13      16'h803a
`define PCG_PRE_19      16'h8027
`define PCG_PRE_24      16'h801f
`define PCG_PRE_27      16'h801b
`define PCG_STRAP_DFLT  2'h2
`endif

// file: common/pcg_pkg.sv
// types shared by the clock control block
package pcg_pkg;
    typedef enum logic [2:0] {
        ST_BOOT,
        ST_IDLE,
        ST_LOCK,
        ST_DIV,
        ST_SRC
    } pcg_state_e;
    typedef logic [15:0] pcg_cfg_t;
endpackage : pcg_pkg

// file: logic/pcg_top.sv
// clock generation control: synth settings, update sequencer, dividers
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "pcg_params.svh"
// What this block does
// - five synthesizer settings: core, array, display, interface, memory
// - each has 8-bit multiplier, 5-bit reference divider, 3-bit exponent
// - output ratio is 2*(mult+1) over 2^exp*(refdiv+1)
// - core and array settings apply only on their update bit
// - full lock wait of 520 reference periods after applying settings
// - exponent-only change shortens lock wait to 10 periods
// - processor and system clocks held glitchless while their source synth locks
// - synth, divider and source selection update independently
// - after reset system clocks run 96 MHz from strap presets
// - integer divider divides by 1 to 64
// - fixed divide by two and selectable divide by 4,3,2,1
// - peripheral reference clocks stay fixed across system changes
// - 24 MHz default, 13, 19.2, 27 MHz strap presets
// - two straps sampled at reset release pick the preset
// - wait 500 reference periods after reset release
module pcg_top (
    // clock and reset
    input  wire logic                  REF_CLK_I,
    input  wire logic                  SYS_RST_I,
    // crystal reference and straps
    input  wire logic                  XTAL_CLK_I,
    input  wire logic [1:0]            STRAP_I,
    // ahb-lite slave
    input  wire logic                  HSEL_I,
    input  wire logic [31:0]           HADDR_I,
    input  wire logic [1:0]            HTRANS_I,
    input  wire logic                  HWRITE_I,
    input  wire logic [2:0]            HSIZE_I,
    input  wire logic [31:0]           HWDATA_I,
    input  wire logic                  HREADY_I,
    output logic [31:0]                HRDATA_O,
    output logic                       HREADYOUT_O,
    output logic                       HRESP_O,
    // synthesizer and clock tree controls
    output pcg_pkg::pcg_cfg_t [4:0]    SYNTH_CFG_O,
    output logic                       SYS_SRC_O,
    output logic                       SYS_HOLD_O,
    output logic                       SYS_CLK_EN_O,
    output logic                       HALF_CLK_EN_O,
    output logic [4:0]                 GATE_O,
    output logic                       BOOT_DONE_O
);
    import pcg_pkg::*;

    pcg_state_e       state_reg;
    pcg_cfg_t [4:0]   stage_reg;
    pcg_cfg_t [4:0]   cfg_reg;
    logic [5:0]       div_stage_reg;
    logic [5:0]       div_reg;
    logic [1:0]       sel_stage_reg;
    logic [1:0]       sel_reg;
    logic             src_stage_reg;
    logic             src_reg;
    logic [3:0]       upd_reg;
    logic [3:0]       upd_clr;
    logic [4:0]       gate_reg;
    logic [1:0]       strap_reg;
    logic             strap_done_reg;
    logic             xtal_d_reg;
    logic             ref_tick;
    logic [9:0]       lock_cnt_reg;
    logic [9:0]       lock_len_reg;
    logic             lock_idx_reg;
    logic             lock_sel;
    logic [5:0]       int_cnt_reg;
    logic             int_tick;
    logic [1:0]       sel_cnt_reg;
    logic             sel_tick;
    logic             half_reg;
    logic             hold;
    logic             only_exp;
    logic             wr_pend_reg;
    logic [7:0]       wr_addr_reg;
    logic             acc;
    logic [7:0]       a;
    pcg_cfg_t         preset;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    // ---------------------------------------------------------------
    // reference edge, straps and boot presets
    // ---------------------------------------------------------------
    // xtal pin is taken as synchronous, so a plain edge detect serves
    assign ref_tick = XTAL_CLK_I & ~xtal_d_reg;

    // follows the pin through reset too, so release brings no false edge
    always_ff @(posedge REF_CLK_I) begin
        xtal_d_reg <= XTAL_CLK_I;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            strap_reg      <= `PCG_STRAP_DFLT;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_reg      <= STRAP_I;
            strap_done_reg <= 1'b1;
        end
    end

    always_comb begin
        case (STRAP_I)
            2'h0:    preset = `PCG_PRE_13;
            2'h1:    preset = `PCG_PRE_19;
            2'h3:    preset = `PCG_PRE_27;
            default: preset = `PCG_PRE_24;
        endcase
    end

    AST_STRAP_CAPTURE: assert property (
        $rose(strap_done_reg) |-> strap_reg == $past(STRAP_I))
        else $error("strap not captured at release");

    // ---------------------------------------------------------------
    // update sequencer
    // ---------------------------------------------------------------
    // compare the synth that idle is about to lock, not the last one
    assign lock_sel = ~upd_reg[`PCG_UPD_CORE];
    assign only_exp = (stage_reg[lock_sel][12:0]
                       == cfg_reg[lock_sel][12:0]);

    // clear in the cycle that leaves a state, so idle never sees it again
    always_comb begin
        upd_clr = 4'h0;
        case (state_reg)
            ST_LOCK: begin
                if (ref_tick
                    && lock_cnt_reg == lock_len_reg - 10'h001) begin
                    upd_clr[{1'b0, lock_idx_reg}] = 1'b1;
                end
            end
            ST_DIV: begin
                upd_clr[`PCG_UPD_DIV] = sel_tick;
            end
            ST_SRC: begin
                upd_clr[`PCG_UPD_SRC] = int_tick;
            end
            default: begin
                upd_clr = 4'h0;
            end
        endcase
    end
    // hold the managed clocks during boot, during a source switch, and while their own source is locking
    assign hold = (state_reg == ST_BOOT) || (state_reg == ST_SRC)
                  || ((state_reg == ST_LOCK)
                      && (lock_idx_reg == src_reg));

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            state_reg    <= ST_BOOT;
            lock_cnt_reg <= 10'h000;
            lock_idx_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_BOOT: begin
                    if (ref_tick) begin
                        lock_cnt_reg <= lock_cnt_reg + 10'h001;
                    end
                    if (ref_tick
                        && lock_cnt_reg == `PCG_BOOT_WAIT - 10'h001) begin
                        state_reg    <= ST_IDLE;
                        lock_cnt_reg <= 10'h000;
                    end
                end
                ST_IDLE: begin
                    if (upd_reg[`PCG_UPD_CORE] || upd_reg[`PCG_UPD_ARRAY])
                    begin
                        state_reg    <= ST_LOCK;
                        lock_idx_reg <= lock_sel;
                        lock_cnt_reg <= 10'h000;
                    end else if (upd_reg[`PCG_UPD_DIV]) begin
                        state_reg <= ST_DIV;
                    end else if (upd_reg[`PCG_UPD_SRC]) begin
                        state_reg <= ST_SRC;
                    end
                end
                ST_LOCK: begin
                    if (ref_tick) begin
                        lock_cnt_reg <= lock_cnt_reg + 10'h001;
                    end
                    if (ref_tick
                        && lock_cnt_reg == lock_len_reg - 10'h001) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_DIV: begin
                    // load at a period boundary so no pulse is cut short
                    if (sel_tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_SRC: begin
                    if (int_tick) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // lock length is fixed on the cycle that enters the lock state
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            lock_len_reg <= `PCG_LOCK_FULL;
        end else if (state_reg == ST_IDLE) begin
            lock_len_reg <= only_exp ? `PCG_LOCK_SHORT
                                     : `PCG_LOCK_FULL;
        end
    end

    AST_LOCK_LEN: assert property (
        ($past(state_reg) == ST_IDLE && state_reg == ST_LOCK)
        |-> lock_len_reg == ($past(only_exp) ? `PCG_LOCK_SHORT
                                             : `PCG_LOCK_FULL))
        else $error("lock length does not match change");
    AST_LOCK_END: assert property (
        ($past(state_reg) == ST_LOCK && state_reg == ST_IDLE)
        |-> $past(lock_cnt_reg) == lock_len_reg - 10'h001)
        else $error("lock ended early or late");
    AST_BOOT_WAIT: assert property (
        $rose(BOOT_DONE_O) |-> $past(lock_cnt_reg) == `PCG_BOOT_WAIT - 10'h001)
        else $error("boot wait not 500 periods");
    AST_HOLD_GATES: assert property (
        hold |=> !SYS_CLK_EN_O)
        else $error("system clock pulse during hold");
    COV_FULL_LOCK: cover property (
        state_reg == ST_LOCK && lock_len_reg == `PCG_LOCK_FULL);
    COV_SHORT_LOCK: cover property (
        state_reg == ST_LOCK && lock_len_reg == `PCG_LOCK_SHORT);

    // ---------------------------------------------------------------
    // applied settings
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            cfg_reg <= {5{`PCG_PRE_24}};
        end else if (!strap_done_reg) begin
            cfg_reg <= {5{preset}};
        end else begin
            if (state_reg == ST_IDLE && upd_reg[`PCG_UPD_CORE]) begin
                cfg_reg[0] <= stage_reg[0];
            end else if (state_reg == ST_IDLE
                         && upd_reg[`PCG_UPD_ARRAY]) begin
                cfg_reg[1] <= stage_reg[1];
            end
            // unprotected synths follow the staging copy directly
            cfg_reg[4:2] <= stage_reg[4:2];
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            div_reg <= 6'h00;
            sel_reg <= 2'h0;
        end else if (state_reg == ST_DIV && sel_tick) begin
            div_reg <= div_stage_reg;
            sel_reg <= sel_stage_reg;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            src_reg <= 1'b0;
        end else if (state_reg == ST_SRC && int_tick) begin
            src_reg <= src_stage_reg;
        end
    end

    AST_CORE_ON_KICK: assert property (
        ($past(strap_done_reg) && cfg_reg[0] != $past(cfg_reg[0]))
        |-> $past(state_reg == ST_IDLE && upd_reg[`PCG_UPD_CORE]))
        else $error("core settings changed without kick");
    AST_DIV_INDEP: assert property (
        (div_reg != $past(div_reg)) |-> $past(state_reg == ST_DIV))
        else $error("divider changed outside its update");
    AST_SRC_SAFE: assert property (
        (src_reg != $past(src_reg))
        |-> $past(state_reg == ST_SRC && int_tick))
        else $error("source switched off a safe point");
    COV_SRC_SWITCH: cover property (
        state_reg == ST_SRC && int_tick);

    // ---------------------------------------------------------------
    // dividers
    // ---------------------------------------------------------------
    assign int_tick = (int_cnt_reg == div_reg);
    assign sel_tick = int_tick && (sel_cnt_reg == sel_reg);

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            int_cnt_reg <= 6'h00;
        end else if (int_tick) begin
            int_cnt_reg <= 6'h00;
        end else begin
            int_cnt_reg <= int_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            sel_cnt_reg <= 2'h0;
            half_reg    <= 1'b0;
        end else if (sel_tick) begin
            sel_cnt_reg <= 2'h0;
            half_reg    <= ~half_reg;
        end else if (int_tick) begin
            sel_cnt_reg <= sel_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            SYS_CLK_EN_O  <= 1'b0;
            HALF_CLK_EN_O <= 1'b0;
        end else begin
            SYS_CLK_EN_O  <= sel_tick && !hold;
            HALF_CLK_EN_O <= sel_tick && half_reg && !hold;
        end
    end

    AST_INT_PERIOD: assert property (
        (int_tick && $past(int_tick) && !$past(int_tick, 2))
        |-> div_reg == 6'h00)
        else $error("integer divider period wrong");

    // ---------------------------------------------------------------
    // ahb-lite register access
    // ---------------------------------------------------------------
    assign acc = HSEL_I && HREADY_I && HTRANS_I[1];
    assign a   = HADDR_I[7:0];

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= acc && HWRITE_I;
            wr_addr_reg <= a;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            stage_reg     <= {5{`PCG_PRE_24}};
            div_stage_reg <= 6'h00;
            sel_stage_reg <= 2'h0;
            src_stage_reg <= 1'b0;
            gate_reg      <= 5'h00;
        end else if (!strap_done_reg) begin
            stage_reg <= {5{preset}};
        end else if (wr_pend_reg) begin
            for (int i = 0; i < 5; i++) begin
                if (wr_addr_reg == `PCG_SYNTH_BASE + 8'(4 * i)) begin
                    stage_reg[i] <= HWDATA_I[15:0];
                end
            end
            if (wr_addr_reg == `PCG_SYSCTL) begin
                div_stage_reg <= HWDATA_I[`PCG_DIV_LSB +: 6];
                sel_stage_reg <= HWDATA_I[`PCG_SEL_LSB +: 2];
                src_stage_reg <= HWDATA_I[`PCG_SRC_BIT];
            end else if (wr_addr_reg == `PCG_GATE) begin
                gate_reg <= HWDATA_I[4:0];
            end
        end
    end

    // a fresh kick in the completion cycle stays pending
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            upd_reg <= 4'h0;
        end else if (wr_pend_reg && wr_addr_reg == `PCG_UPDATE) begin
            upd_reg <= (upd_reg & ~upd_clr) | HWDATA_I[3:0];
        end else begin
            upd_reg <= upd_reg & ~upd_clr;
        end
    end

    AST_PEND_CLEAR: assert property (
        $fell(upd_reg[`PCG_UPD_DIV]) |-> $past(state_reg == ST_DIV))
        else $error("divider update cleared before done");
    COV_KICK_DONE: cover property ($fell(upd_reg[`PCG_UPD_CORE]));

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (acc && !HWRITE_I) begin
            HRDATA_O <= 32'h0000_0000;
            if (a < `PCG_SYSCTL && a[1:0] == 2'h0) begin
                HRDATA_O[15:0] <= stage_reg[a[4:2]];
            end else if (a == `PCG_SYSCTL) begin
                HRDATA_O[`PCG_DIV_LSB +: 6] <= div_stage_reg;
                HRDATA_O[`PCG_SEL_LSB +: 2] <= sel_stage_reg;
                HRDATA_O[`PCG_SRC_BIT]      <= src_stage_reg;
            end else if (a == `PCG_UPDATE) begin
                HRDATA_O[3:0] <= upd_reg;
            end else if (a == `PCG_STATUS) begin
                HRDATA_O[1:0]          <= strap_reg;
                HRDATA_O[`PCG_ST_BOOT] <= state_reg != ST_BOOT;
                HRDATA_O[`PCG_ST_BUSY] <= state_reg != ST_IDLE;
            end else if (a == `PCG_GATE) begin
                HRDATA_O[4:0] <= gate_reg;
            end
        end
    end

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign SYNTH_CFG_O = cfg_reg;
    assign SYS_SRC_O   = src_reg;
    assign SYS_HOLD_O  = hold;
    // peripheral gates only; their ref clocks never follow system changes
    assign GATE_O      = gate_reg;
    assign BOOT_DONE_O = (state_reg != ST_BOOT) && strap_done_reg;

endmodule : pcg_top

// file: dv/tb.sv
// self-checking bench for the clock generation control block
`timescale 1ns/1ps
`include "pcg_params.svh"
module tb;
    import pcg_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic           clk    = 1'b0;
    logic           rst    = 1'b1;
    logic           xtal   = 1'b0;
    logic [1:0]     strap  = 2'h0;
    logic           hsel   = 1'b0;
    logic [31:0]    haddr  = 32'h0;
    logic [1:0]     htrans = 2'h0;
    logic           hwrite = 1'b0;
    logic [2:0]     hsize  = 3'h2;
    logic [31:0]    hwdata = 32'h0;
    logic [31:0]    hrdata;
    logic           hready;
    logic           hresp;
    pcg_cfg_t [4:0] cfg;
    logic           sys_src;
    logic           sys_hold;
    logic           sys_en;
    logic           half_en;
    logic [4:0]     gate;
    logic           boot_done;
    logic [31:0]    seed   = 32'd51530;
    int             miscompares = 0;
    int             comparisons = 0;
    int             xcnt = 0;

    always #2 clk = ~clk;
    // crystal well below half the system rate, edges clear of clk rising edges
    always #16 xtal = ~xtal;
    always @(posedge xtal) xcnt++;

    pcg_top u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .XTAL_CLK_I(xtal),
        .STRAP_I(strap), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .SYNTH_CFG_O(cfg), .SYS_SRC_O(sys_src),
        .SYS_HOLD_O(sys_hold), .SYS_CLK_EN_O(sys_en),
        .HALF_CLK_EN_O(half_en), .GATE_O(gate), .BOOT_DONE_O(boot_done));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic pcg_cfg_t preset(input logic [1:0] s);
        case (s)
            2'h0: return `PCG_PRE_13;
            2'h1: return `PCG_PRE_19;
            2'h2: return `PCG_PRE_24;
            default: return `PCG_PRE_27;
        endcase
    endfunction : preset

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_val({31'h0, got}, {31'h0, exp});
    endtask : cmp_flag

    // address phase held until hready, then data phase until hready
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, {24'h0, a}, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ahb(1'b0, {24'h0, a}, 32'h0, d);
    endtask : rd

    // kick one update bit and count crystal edges until it clears
    task automatic kick(input int b, input logic hold, output int e);
        logic [31:0] d;
        int          k;
        e = xcnt;
        wr(`PCG_UPDATE, 32'h1 << b);
        rd(`PCG_UPDATE, d);
        cmp_flag(d[b], 1'b1);
        if (b < 2) cmp_flag(sys_hold, hold);
        for (k = 0; k < 3000 && d[b] !== 1'b0; k++) rd(`PCG_UPDATE, d);
        cmp_flag(d[b], 1'b0);
        e = xcnt - e;
    endtask : kick

    task automatic gap(input logic half, output int n);
        int k;
        k = 0;
        do @(posedge clk); while ((half ? half_en : sys_en) !== 1'b1
                                  && ++k < 600);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((half ? half_en : sys_en) !== 1'b1 && n < 600);
    endtask : gap

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end

    initial begin
        logic [31:0] d;
        logic [1:0]  st;
        pcg_cfg_t    v;
        logic [31:0] w;
        int          k, e, n, dv, sv;
        d = xs();
        st = d[1:0];
        strap <= st;
        repeat (6) @(posedge clk);
        for (k = 0; k < 5; k++) cmp_val(cfg[k], 32'h801f);
        cmp_flag(boot_done, 1'b0);
        rst <= 1'b0;
        e = xcnt;
        repeat (3) @(posedge clk);
        for (k = 0; k < 5; k++) cmp_val(cfg[k], preset(st));
        for (k = 0; k < 6000 && boot_done !== 1'b1; k++) @(posedge clk);
        cmp_flag(xcnt - e >= 499 && xcnt - e <= 502, 1'b1);
        $display("test boot finished");
        rd(`PCG_STATUS, d);
        cmp_val(d, {28'h0, 2'h1, st});
        wr(`PCG_STATUS, 32'hffffffff);
        cmp_flag(hresp, 1'b0);
        rd(`PCG_STATUS, d);
        cmp_val(d, {28'h0, 2'h1, st});
        rd(8'h40, d);
        cmp_val(d, 32'h0);
        wr(`PCG_GATE, 32'h0000000f);
        for (k = 0; k < 5; k++) begin
            w = xs();
            // applied synths only get a small legal step from the preset
            if (k >= 2) w[15:0] = preset(st) ^ {13'h0, w[2:0]};
            wr(8'(4 * k), w);
            rd(8'(4 * k), d);
            cmp_val(d, {16'h0, w[15:0]});
            if (k < 2) cmp_val(cfg[k], preset(st));
            else cmp_val(cfg[k], w[15:0]);
        end
        $display("test staging finished");
        v = preset(st) ^ 16'h0001;
        wr(`PCG_SYNTH_BASE, v);
        kick(0, 1'b1, e);
        cmp_val(cfg[0], v);
        cmp_flag(e >= 518 && e <= 523, 1'b1);
        cmp_flag(sys_hold, 1'b0);
        v = v ^ 16'h2000;
        wr(`PCG_SYNTH_BASE, v);
        kick(0, 1'b1, e);
        cmp_val(cfg[0], v);
        cmp_flag(e >= 8 && e <= 13, 1'b1);
        v = preset(st) ^ 16'h2000;
        wr(8'h04, v);
        kick(1, 1'b0, e);
        cmp_val(cfg[1], v);
        cmp_flag(e >= 8 && e <= 13, 1'b1);
        $display("test lock finished");
        for (k = 0; k < 3; k++) begin
            d = xs();
            dv = (k == 0) ? 0 : (k == 1) ? 63 : int'(d[5:0]);
            sv = (k == 0) ? 0 : (k == 1) ? 3 : int'(d[9:8]);
            wr(`PCG_SYSCTL, 32'(dv) | (32'(sv) << 8));
            kick(2, 1'b0, e);
            gap(1'b0, n);
            cmp_val(n, (dv + 1) * (sv + 1));
            gap(1'b1, n);
            cmp_val(n, 2 * (dv + 1) * (sv + 1));
            cmp_flag(sys_src, 1'b0);
            cmp_val(cfg[0], preset(st) ^ 16'h2001);
        end
        $display("test divider finished");
        wr(`PCG_SYSCTL, 32'h1000 | 32'(dv) | (32'(sv) << 8));
        cmp_flag(sys_src, 1'b0);
        kick(3, 1'b0, e);
        cmp_flag(sys_src, 1'b1);
        gap(1'b0, n);
        cmp_val(n, (dv + 1) * (sv + 1));
        $display("test source finished");
        w = xs() & 32'h0000000f;
        wr(`PCG_GATE, w);
        @(posedge clk);
        cmp_val(gate, w[4:0]);
        rd(`PCG_GATE, d);
        cmp_val(d, {27'h0, w[4:0]});
        $display("test gate finished");
        report_and_stop();
    end
endmodule : tb
